//--- bit_flag_unit.sv
// flag and single-bit execution unit of an 8-bit core, commanded over apb
// assumes apb master on pclk; io_event comes from pins and is synchronised here
//
// Notes on behaviour
// RULE1 - rotate right through carry, flags, one cycle
// RULE2 - arithmetic shift right keeps sign, flags updated
// RULE3 - copy chosen operand bit into transfer flag
// RULE4 - copy transfer flag into chosen operand bit
// RULE5 - set signed flag only
// RULE6 - clear signed flag only
// RULE7 - set overflow flag only
// RULE8 - clear overflow flag only
// RULE9 - set half carry flag only
// RULE10 - software writes reserved bits as zero
// RULE11 - software never writes reserved io addresses
// RULE12 - io bit set/clear only below 0x20
// RULE13 - skip tests read one io bit
// RULE14 - writing one clears event flags
// RULE15 - io bit ops touch only addressed bit
// RULE16 - nibble swap, flags unchanged
// RULE17 - indexed flag set and clear
// RULE18 - dedicated set/clear of c, n, z, t
`timescale 1ns/1ps
module bit_flag_unit (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic [7:0] io_event,
    output logic [7:0] flags_out,
    output logic [7:0] operand_out,
    output logic skip_next
);
    import bitop_pkg::*;

    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] operand_q;
    logic [7:0] operand_d;
    logic skip_q;
    logic skip_d;
    logic refused_q;
    logic refused_d;
    logic [31:0] prdata_q;
    logic [7:0] ev_meta_q;
    logic [7:0] ev_sync_q;
    logic [7:0] io_q [IO_REGS];

    logic access;
    logic mapped;
    logic exec;
    opcode_t opc;
    logic [2:0] bidx;
    logic [5:0] ioa;
    logic [4:0] io_idx;
    logic io_ok;
    logic io_we;
    logic [7:0] io_mask;
    logic [7:0] io_wdata;
    logic [7:0] sh_res;
    logic sh_c;
    logic sh_z;
    logic sh_n;
    logic sh_v;

    // zero wait states: every access completes in its first access cycle
    assign access = psel & penable;
    assign pready = 1'b1;
    assign mapped = (paddr == CTRL_OFS) || (paddr == OPND_OFS) ||
                    (paddr == FLAG_OFS) || (paddr == STAT_OFS);
    assign pslverr = access & ~mapped;

    // a write to the command word starts the command at the access edge
    assign exec = access & pwrite & (paddr == CTRL_OFS);
    assign opc = opcode_t'(pwdata[OPC_LSB +: 5]);
    assign bidx = pwdata[BIDX_LSB +: 3];
    assign ioa = pwdata[IOA_LSB +: 6];
    assign io_idx = ioa[4:0];
    assign io_ok = (ioa <= IO_BIT_TOP); // RULE12

    assign flags_out = flags_q;
    assign operand_out = operand_q;
    assign skip_next = skip_q;

    // read data is captured in the setup cycle so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OPND_OFS: prdata_q <= {24'h00_0000, operand_q};
                FLAG_OFS: prdata_q <= {24'h00_0000, flags_q};
                STAT_OFS: prdata_q <= {30'h0000_0000, refused_q, skip_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign prdata = prdata_q;

    // pin events pass two flops before the event register sees them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_meta_q <= 8'h00;
            ev_sync_q <= 8'h00;
        end else begin
            ev_meta_q <= io_event;
            ev_sync_q <= ev_meta_q;
        end
    end

    shift_unit u_shift (
        .op(opc),
        .din(operand_q),
        .c_in(flags_q[C_POS]),
        .dout(sh_res),
        .c_out(sh_c),
        .z_out(sh_z),
        .n_out(sh_n),
        .v_out(sh_v)
    );

    // io window; only the event register carries write-one-to-clear flags
    genvar gi;
    generate
        for (gi = 0; gi < IO_REGS; gi++) begin : g_io
            io_byte #(
                .W1C_MASK(gi == EVT_IO_IDX ? EVT_W1C_MASK : 8'h00)
            ) u_io (
                .pclk(pclk),
                .presetn(presetn),
                .wr_en(io_we && (io_idx == 5'(gi))),
                .wr_mask(io_mask),
                .wr_data(io_wdata),
                .hw_set(gi == EVT_IO_IDX ? ev_sync_q : 8'h00),
                .q(io_q[gi])
            );
        end
    endgenerate

    // command decode; register writes from software share the same next-state
    always_comb begin
        flags_d = flags_q;
        operand_d = operand_q;
        skip_d = skip_q;
        refused_d = refused_q;
        io_we = 1'b0;
        io_mask = 8'h00;
        io_wdata = 8'h00;
        if (access && pwrite && paddr == OPND_OFS) begin
            operand_d = pwdata[7:0];
        end
        if (access && pwrite && paddr == FLAG_OFS) begin
            flags_d = pwdata[7:0];
        end
        if (exec) begin
            skip_d = 1'b0;
            refused_d = 1'b0;
            unique case (opc)
                OP_ROT_RC, OP_ASHR: begin
                    operand_d = sh_res; // RULE1 RULE2
                    flags_d[C_POS] = sh_c;
                    flags_d[Z_POS] = sh_z;
                    flags_d[N_POS] = sh_n;
                    flags_d[V_POS] = sh_v;
                end
                OP_SWAP: operand_d = sh_res; // RULE16
                OP_FSET: flags_d[bidx] = 1'b1; // RULE17
                OP_FCLR: flags_d[bidx] = 1'b0; // RULE17
                OP_T_STORE: flags_d[T_POS] = operand_q[bidx]; // RULE3
                OP_T_LOAD: operand_d[bidx] = flags_q[T_POS]; // RULE4
                OP_SEC: flags_d[C_POS] = 1'b1; // RULE18
                OP_CLC: flags_d[C_POS] = 1'b0; // RULE18
                OP_SEN: flags_d[N_POS] = 1'b1; // RULE18
                OP_CLN: flags_d[N_POS] = 1'b0; // RULE18
                OP_SEZ: flags_d[Z_POS] = 1'b1; // RULE18
                OP_CLZ: flags_d[Z_POS] = 1'b0; // RULE18
                OP_SGN_SET: flags_d[S_POS] = 1'b1; // RULE5
                OP_SGN_CLR: flags_d[S_POS] = 1'b0; // RULE6
                OP_OVF_SET: flags_d[V_POS] = 1'b1; // RULE7
                OP_OVF_CLR: flags_d[V_POS] = 1'b0; // RULE8
                OP_SET: flags_d[T_POS] = 1'b1; // RULE18
                OP_CLT: flags_d[T_POS] = 1'b0; // RULE18
                OP_HC_SET: flags_d[H_POS] = 1'b1; // RULE9
                OP_CLH: flags_d[H_POS] = 1'b0;
                OP_IOSET, OP_IOCLR: begin
                    // single-lane write keeps event flags in other lanes intact
                    io_we = io_ok; // RULE12
                    io_mask = 8'h01 << bidx; // RULE15
                    io_wdata = (opc == OP_IOSET) ? 8'hFF : 8'h00; // RULE14
                    refused_d = ~io_ok;
                end
                OP_IOSKS, OP_IOSKC: begin
                    // the core's fetch stage consumes skip_next
                    skip_d = io_ok && (io_q[io_idx][bidx] == (opc == OP_IOSKS)); // RULE13
                    refused_d = ~io_ok;
                end
                OP_IOWR: begin
                    // writes above the window are dropped and flagged
                    io_we = io_ok; // RULE12
                    io_mask = 8'hFF;
                    io_wdata = operand_q;
                    refused_d = ~io_ok;
                end
                OP_IORD: begin
                    operand_d = io_ok ? io_q[io_idx] : operand_q;
                    refused_d = ~io_ok;
                end
                default: begin
                    operand_d = operand_q;
                end
            endcase
        end
    end

    // operand and flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= FLAGS_RST;
            operand_q <= OPND_RST;
        end else begin
            flags_q <= flags_d;
            operand_q <= operand_d;
        end
    end

    // skip and refusal status hold until the next command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
            refused_q <= refused_d;
        end
    end

    // helper state for the checks: command and values before it ran
    logic chk_exec_q;
    opcode_t chk_opc_q;
    logic [2:0] chk_bidx_q;
    logic chk_ok_q;
    logic [7:0] chk_flags_q;
    logic [7:0] chk_opnd_q;
    logic [4:0] chk_idx_q;
    logic [7:0] chk_iov_q;
    logic [7:0] chk_ev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_exec_q <= 1'b0;
            chk_opc_q <= OP_NOP;
            chk_bidx_q <= 3'h0;
            chk_ok_q <= 1'b0;
            chk_flags_q <= FLAGS_RST;
            chk_opnd_q <= OPND_RST;
            chk_idx_q <= 5'h00;
            chk_iov_q <= IO_RST;
            chk_ev_q <= 8'h00;
        end else begin
            chk_exec_q <= exec;
            chk_opc_q <= opc;
            chk_bidx_q <= bidx;
            chk_ok_q <= io_ok;
            chk_flags_q <= flags_q;
            chk_opnd_q <= operand_q;
            chk_idx_q <= io_idx;
            chk_iov_q <= io_q[io_idx];
            chk_ev_q <= ev_sync_q;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rot_result_a: assert property (chk_exec_q && chk_opc_q == OP_ROT_RC |-> // RULE1
        operand_q == {chk_flags_q[C_POS], chk_opnd_q[7:1]} && flags_q[C_POS] == chk_opnd_q[0] &&
        flags_q[V_POS] == (operand_q[7] ^ flags_q[C_POS]))
        else $error("rotate right result wrong");
    ashr_result_a: assert property (chk_exec_q && chk_opc_q == OP_ASHR |-> // RULE2
        operand_q == {chk_opnd_q[7], chk_opnd_q[7:1]} && flags_q[Z_POS] == (operand_q == 8'h00))
        else $error("arithmetic shift result wrong");
    tflag_store_a: assert property (chk_exec_q && chk_opc_q == OP_T_STORE |-> // RULE3
        flags_q[T_POS] == chk_opnd_q[chk_bidx_q] && flags_q[5:0] == chk_flags_q[5:0])
        else $error("bit store to transfer flag wrong");
    tflag_load_a: assert property (chk_exec_q && chk_opc_q == OP_T_LOAD |-> // RULE4
        operand_q[chk_bidx_q] == chk_flags_q[T_POS] && flags_q == chk_flags_q)
        else $error("bit load from transfer flag wrong");
    sgn_set_a: assert property (chk_exec_q && chk_opc_q == OP_SGN_SET |-> // RULE5
        flags_q == (chk_flags_q | 8'h10))
        else $error("signed flag set wrong");
    sgn_clear_a: assert property (chk_exec_q && chk_opc_q == OP_SGN_CLR |-> // RULE6
        flags_q == (chk_flags_q & 8'hEF))
        else $error("signed flag clear wrong");
    ovf_set_a: assert property (exec && opc == OP_OVF_SET |=> flags_q == (chk_flags_q | 8'h08)) // RULE7
        else $error("overflow set wrong");
    ovf_clear_a: assert property (exec && opc == OP_OVF_CLR |=> flags_q == (chk_flags_q & 8'hF7)) // RULE8
        else $error("overflow clear wrong");
    hc_set_a: assert property (exec && opc == OP_HC_SET |=> flags_q == (chk_flags_q | 8'h20)) // RULE9
        else $error("half carry set wrong");
    io_refuse_a: assert property (chk_exec_q && chk_opc_q inside {OP_IOSET, OP_IOCLR} |-> // RULE12
        refused_q == !chk_ok_q)
        else $error("io window check wrong");
    swap_keep_a: assert property (exec && opc == OP_SWAP |=> // RULE16
        operand_q == {chk_opnd_q[3:0], chk_opnd_q[7:4]} && flags_q == chk_flags_q)
        else $error("nibble swap wrong");
    fset_index_a: assert property (chk_exec_q && chk_opc_q == OP_FSET |-> // RULE17
        flags_q == (chk_flags_q | (8'h01 << chk_bidx_q)))
        else $error("indexed flag set wrong");


    // dedicated flag commands and the indexed clear touch one flag only
    carry_set_a: assert property (chk_exec_q && chk_opc_q == OP_SEC |-> // RULE18
        flags_q == (chk_flags_q | 8'h01))
        else $error("carry set wrong");
    neg_set_a: assert property (chk_exec_q && chk_opc_q == OP_SEN |-> // RULE18
        flags_q == (chk_flags_q | 8'h04))
        else $error("negative set wrong");
    zero_clear_a: assert property (chk_exec_q && chk_opc_q == OP_CLZ |-> // RULE18
        flags_q == (chk_flags_q & 8'hFD))
        else $error("zero clear wrong");
    tflag_clear_a: assert property (chk_exec_q && chk_opc_q == OP_CLT |-> // RULE18
        flags_q == (chk_flags_q & 8'hBF))
        else $error("transfer flag clear wrong");
    fclr_index_a: assert property (chk_exec_q && chk_opc_q == OP_FCLR |-> // RULE17
        flags_q == (chk_flags_q & ~(8'h01 << chk_bidx_q)))
        else $error("indexed flag clear wrong");

    // io commands: skip follows the tested bit, a lane write spares the others, a written one clears an event flag unless an event lands in the same cycle
    skip_result_a: assert property (chk_exec_q && chk_opc_q inside {OP_IOSKS, OP_IOSKC} |-> // RULE13
        skip_q == (chk_ok_q && (chk_iov_q[chk_bidx_q] == (chk_opc_q == OP_IOSKS))))
        else $error("skip result wrong");
    io_lane_a: assert property (chk_exec_q && chk_opc_q == OP_IOSET && chk_ok_q && // RULE15
        chk_idx_q != 5'(EVT_IO_IDX) |-> io_q[chk_idx_q] == (chk_iov_q | (8'h01 << chk_bidx_q)))
        else $error("io lane set wrong");
    evt_clear_a: assert property (chk_exec_q && chk_opc_q == OP_IOSET && chk_ok_q && // RULE14
        chk_idx_q == 5'(EVT_IO_IDX) |-> (io_q[EVT_IO_IDX] & EVT_W1C_MASK & (8'h01 << chk_bidx_q) & ~chk_ev_q) == 8'h00)
        else $error("event flag clear wrong");

    rot_run_c: cover property (exec && opc == OP_ROT_RC ##1 flags_q[C_POS]);
    io_set_c: cover property (exec && opc == OP_IOSET && io_idx == 5'(EVT_IO_IDX));
    skip_hit_c: cover property (exec && opc == OP_IOSKS ##1 skip_q);
    refuse_c: cover property (exec && opc == OP_IOSET && !io_ok);
    evt_clear_c: cover property (exec && opc == OP_IOSET && io_idx == 5'(EVT_IO_IDX) && bidx == 3'h4);
endmodule

//--- bitop_pkg.sv
// constants, field layout and command codes shared by the bit and flag unit
// assumes a single pclk domain; software issues commands through apb writes
package bitop_pkg;

    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] OPND_OFS = 8'h04;
    localparam logic [7:0] FLAG_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;

    // command word fields
    localparam int OPC_LSB = 0;
    localparam int BIDX_LSB = 8;
    localparam int IOA_LSB = 16;

    // status word fields
    localparam int SKIP_POS = 0;
    localparam int REFUSED_POS = 1;

    // processor flag bit positions
    localparam int C_POS = 0;
    localparam int Z_POS = 1;
    localparam int N_POS = 2;
    localparam int V_POS = 3;
    localparam int S_POS = 4;
    localparam int H_POS = 5;
    localparam int T_POS = 6;
    localparam int I_POS = 7;

    // values after reset
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] OPND_RST = 8'h00;
    localparam logic [7:0] IO_RST = 8'h00;

    // bit-addressable io window and the event register inside it
    localparam logic [5:0] IO_BIT_TOP = 6'h1F;
    localparam int IO_REGS = 32;
    localparam int EVT_IO_IDX = 8;
    localparam logic [7:0] EVT_W1C_MASK = 8'h10;

    // every command completes in this many cycles
    localparam int EXEC_CYCLES = 1;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ROT_RC, OP_ASHR, OP_SWAP, OP_FSET, OP_FCLR, OP_T_STORE, OP_T_LOAD,
        OP_SEC, OP_CLC, OP_SEN, OP_CLN, OP_SEZ, OP_CLZ, OP_SGN_SET, OP_SGN_CLR,
        OP_OVF_SET, OP_OVF_CLR, OP_SET, OP_CLT, OP_HC_SET, OP_CLH, OP_IOSET, OP_IOCLR,
        OP_IOSKS, OP_IOSKC, OP_IOWR, OP_IORD
    } opcode_t;

endpackage

//--- io_byte.sv
// one bit-addressable io register; bits in W1C_MASK are hardware event flags
// assumes hw_set is already synchronous to pclk
`timescale 1ns/1ps
module io_byte #(
    parameter logic [7:0] W1C_MASK = 8'h00
) (
    input logic pclk,
    input logic presetn,
    input logic wr_en,
    input logic [7:0] wr_mask,
    input logic [7:0] wr_data,
    input logic [7:0] hw_set,
    output logic [7:0] q
);
    import bitop_pkg::*;

    logic [7:0] clr;
    logic [7:0] plain;

    // a one written to a flag clears it; only masked lanes are touched
    assign clr = (wr_en ? (wr_mask & wr_data) : 8'h00) & W1C_MASK; // RULE14
    assign plain = wr_en ? ((q & ~wr_mask) | (wr_data & wr_mask)) : q; // RULE15

    // event set wins over a clear landing in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= IO_RST;
        end else begin
            q <= (plain & ~W1C_MASK) | (q & W1C_MASK & ~clr) | (hw_set & W1C_MASK);
        end
    end
endmodule

//--- shift_unit.sv
// rotate, arithmetic shift and nibble swap of one byte with the flags they make
// assumes a purely combinational use inside the command stage
`timescale 1ns/1ps
module shift_unit (
    input bitop_pkg::opcode_t op,
    input logic [7:0] din,
    input logic c_in,
    output logic [7:0] dout,
    output logic c_out,
    output logic z_out,
    output logic n_out,
    output logic v_out
);
    import bitop_pkg::*;

    // carry only changes on the two shifts
    always_comb begin
        dout = din;
        c_out = c_in;
        unique case (op)
            OP_ROT_RC: begin
                dout = {c_in, din[7:1]};
                c_out = din[0];
            end
            OP_ASHR: begin
                dout = {din[7], din[7:1]}; // sign bit kept in place
                c_out = din[0];
            end
            OP_SWAP: begin
                dout = {din[3:0], din[7:4]};
            end
            default: begin
                dout = din;
            end
        endcase
    end

    // overflow follows n xor c after a right shift
    assign z_out = (dout == 8'h00);
    assign n_out = dout[7];
    assign v_out = dout[7] ^ c_out;
endmodule

//--- tb_top.sv
// self-checking bench for the flag and single-bit unit, commands sent over apb
// assumes bit_flag_unit answers with zero wait states and uses the codes of bitop_pkg
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    import bitop_pkg::*;
    typedef struct {logic [4:0] op; logic [2:0] b; logic [7:0] od; logic [7:0] fl; logic [7:0] eo; logic [7:0] ef;} row_t;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] io_event;
    logic [7:0] flags_out;
    logic [7:0] operand_out;
    logic skip_next;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    // shift, swap, transfer-flag and no-op cases: operand, flags in, operand and flags out
    row_t rows [13] = '{
        '{5'h01, 3'd0, 8'h81, 8'hF0, 8'h40, 8'hF9}, '{5'h01, 3'd0, 8'h00, 8'h01, 8'h80, 8'h0C},
        '{5'h01, 3'd0, 8'h01, 8'h00, 8'h00, 8'h0B}, '{5'h02, 3'd0, 8'h81, 8'hF0, 8'hC0, 8'hF5},
        '{5'h02, 3'd0, 8'h01, 8'h00, 8'h00, 8'h0B}, '{5'h02, 3'd0, 8'h7E, 8'h0F, 8'h3F, 8'h00},
        '{5'h03, 3'd0, 8'h3C, 8'hA5, 8'hC3, 8'hA5}, '{5'h06, 3'd3, 8'h08, 8'h00, 8'h08, 8'h40},
        '{5'h06, 3'd3, 8'hF7, 8'hFF, 8'hF7, 8'hBF}, '{5'h07, 3'd6, 8'h00, 8'h40, 8'h40, 8'h40},
        '{5'h07, 3'd0, 8'hFF, 8'hBF, 8'hFE, 8'hBF}, '{5'h00, 3'd0, 8'h5A, 8'h5A, 8'h5A, 8'h5A},
        '{5'h1F, 3'd0, 8'hA5, 8'h5A, 8'hA5, 8'h5A}
    };
    // flag positions hit by the dedicated pairs, in opcode order from code 8
    int dpos [7] = '{0, 2, 1, 4, 3, 6, 5};

    bit_flag_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .io_event(io_event), .flags_out(flags_out), .operand_out(operand_out), .skip_next(skip_next));

    // free-running clock, 10 ns period
    always #5 pclk = ~pclk;

    // hang guard: far above the few hundred cycles the sequence needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one apb transfer; entered just after a rising edge, leaves one idle edge after release
    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic do_cmd(input logic [4:0] op, input logic [2:0] b, input logic [5:0] a);
        apb_xfer(1'b1, CTRL_OFS, {10'h000, a, 5'h00, b, 3'h0, op});
    endtask

    task automatic run_case(input row_t r);
        apb_xfer(1'b1, OPND_OFS, {24'h00_0000, r.od});
        apb_xfer(1'b1, FLAG_OFS, {24'h00_0000, r.fl});
        do_cmd(r.op, r.b, 6'h00);
        `CHK("operand", r.eo, operand_out)
        `CHK("flags", r.ef, flags_out)
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        io_event = 8'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("rst flags", 8'h00, flags_out)
        `CHK("rst skip", 1'b0, skip_next)
        apb_xfer(1'b0, OPND_OFS, 32'h0000_0000);
        `CHK("rst operand", 32'h0000_0000, rd)
        // table of ordinary cases
        foreach (rows[i]) begin
            run_case(rows[i]);
        end
        // indexed set and clear over every flag position
        for (int i = 0; i < 8; i++) begin
            run_case('{5'h04, i[2:0], 8'h5A, 8'h00, 8'h5A, 8'h01 << i});
            run_case('{5'h05, i[2:0], 8'h5A, 8'hFF, 8'h5A, ~(8'h01 << i)});
        end
        // dedicated set/clear pairs, set from all-zero and clear from all-one
        for (int k = 0; k < 14; k++) begin
            run_case('{5'd8 + k[4:0], 3'd0, 8'hA5, (k % 2) ? 8'hFF : 8'h00, 8'hA5,
                (k % 2) ? ~(8'h01 << dpos[k / 2]) : (8'h01 << dpos[k / 2])});
        end
        // io single-bit ops touch one lane only; reserved bits written as zero, reserved io addresses never written
        apb_xfer(1'b1, OPND_OFS, 32'h0000_00A5);
        apb_xfer(1'b0, OPND_OFS, 32'h0000_0000);
        `CHK("upper bits", 32'h0000_00A5, rd)
        do_cmd(5'h1A, 3'd0, 6'h06);
        do_cmd(5'h16, 3'd1, 6'h06);
        do_cmd(5'h17, 3'd7, 6'h06);
        do_cmd(5'h1B, 3'd0, 6'h06);
        `CHK("io lanes", 8'h27, operand_out)
        // skip tests on a one and a zero bit, both senses
        do_cmd(5'h18, 3'd0, 6'h06);
        `CHK("skip one", 1'b1, skip_next)
        apb_xfer(1'b0, STAT_OFS, 32'h0000_0000);
        `CHK("stat skip", 32'h0000_0001, rd)
        do_cmd(5'h19, 3'd0, 6'h06);
        `CHK("skipc one", 1'b0, skip_next)
        do_cmd(5'h19, 3'd3, 6'h06);
        `CHK("skipc zero", 1'b1, skip_next)
        do_cmd(5'h18, 3'd3, 6'h06);
        `CHK("skip zero", 1'b0, skip_next)
        // top of window accepted by a read-only test; addresses above refused without aliasing low
        do_cmd(5'h19, 3'd2, 6'h1F);
        `CHK("io top", 1'b1, skip_next)
        do_cmd(5'h16, 3'd0, 6'h21);
        apb_xfer(1'b0, STAT_OFS, 32'h0000_0000);
        `CHK("refused", 32'h0000_0002, rd)
        do_cmd(5'h19, 3'd0, 6'h3F);
        `CHK("skip refused", 1'b0, skip_next)
        do_cmd(5'h1B, 3'd0, 6'h01);
        `CHK("no alias", 8'h00, operand_out)
        // event flag: set by pin, kept by a set on another lane and a zero written to its own lane, cleared by writing one
        io_event <= 8'h10;
        repeat (4) @(posedge pclk);
        io_event <= 8'h00;
        @(posedge pclk);
        do_cmd(5'h16, 3'd3, 6'h08);
        do_cmd(5'h17, 3'd4, 6'h08);
        do_cmd(5'h1B, 3'd0, 6'h08);
        `CHK("event kept", 8'h18, operand_out)
        do_cmd(5'h16, 3'd4, 6'h08);
        do_cmd(5'h1B, 3'd0, 6'h08);
        `CHK("event cleared", 8'h08, operand_out)
        // unmapped address answers with an error and zero data
        apb_xfer(1'b0, 8'h10, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rd)
        // reset in mid-run clears everything at once
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("rerst flags", 8'h00, flags_out)
        `CHK("rerst operand", 8'h00, operand_out)
        presetn <= 1'b1;
        @(posedge pclk);
        close_out();
    end
endmodule
